// file: src/autrf_cfg.svh
// Purpose: offsets, field positions, codes and sizes of the framer
// Assumes: included by bare name, definitions only
// Notes:   all byte addresses are word aligned on a 32-bit apb bus
`ifndef AUTRF_CFG_SVH
`define AUTRF_CFG_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define AUTRF_A_TXCTL 8'h00
`define AUTRF_A_TXDAT 8'h04
`define AUTRF_A_TXEND 8'h08
`define AUTRF_A_TXSTA 8'h0C
`define AUTRF_A_RXDAT 8'h10
`define AUTRF_A_RXCNT 8'h14
`define AUTRF_A_RXINF 8'h18
// ---------------------------------------------------------------
// transaction codes
// ---------------------------------------------------------------
`define AUTRF_TC_WRQ 4'h0
`define AUTRF_TC_WRB 4'h1
`define AUTRF_TC_WRS 4'h2
`define AUTRF_TC_RDQ 4'h4
`define AUTRF_TC_RDB 4'h5
`define AUTRF_TC_RSQ 4'h6
`define AUTRF_TC_RSB 4'h7
`define AUTRF_TC_LKQ 4'h9
`define AUTRF_TC_LKS 4'hB
`define AUTRF_TC_PHY 4'hE
// ---------------------------------------------------------------
// second quadlet kinds, field positions, sizes
// ---------------------------------------------------------------
`define AUTRF_PKT_CFG 2'h0
`define AUTRF_PKT_LON 2'h1
`define AUTRF_CLR_BIT 16
`define AUTRF_BCAST_NODE 6'h3F
`define AUTRF_RX_AW 6
`define AUTRF_RX_DEPTH 64
`endif

// file: src/autrf_pkg.sv
// Purpose: types shared by the framer
// Assumes: nothing
// Notes:   constants live in autrf_cfg.svh
package autrf_pkg;
    // receive layout chosen from the transaction code
    typedef enum logic [1:0] {FMT_NODATA, FMT_QUAD, FMT_BLOCK, FMT_NONE} autrf_fmt_t;
    // receive entry phase
    typedef enum logic [1:0] {RXP_IDLE, RXP_HDR, RXP_PAY, RXP_SKIP} autrf_rxph_t;
    // one quadlet on its way to the link core
    typedef struct packed {
        logic [31:0] data;
        logic first;
        logic last;
        logic crc_en;
    } autrf_txq_t;
    // state of the framer, all but the receive buffer
    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
        autrf_txq_t txq;
        logic tx_full;
        logic tx_unf;
        logic [1:0] tx_idx;
        logic [31:0] tx_q2;
        logic [1:0] tx_kind;
        logic tx_inv_bad;
        logic cfg_root;
        logic [5:0] cfg_target;
        logic cfg_gap;
        logic [5:0] cfg_gapcnt;
        logic gap_pend;
        autrf_rxph_t rx_ph;
        autrf_fmt_t rx_fmt;
        logic [1:0] rx_idx;
        logic [14:0] rx_left;
        logic [6:0] rx_cnt;
        logic [5:0] rx_wp;
        logic [5:0] rx_rp;
        logic rx_ovf;
        logic rx_bad;
        logic [1:0] rx_retry;
        logic [3:0] rx_tcode;
        logic [15:0] rx_ext;
        logic rx_bcast;
        logic rx_local;
        logic [1:0] rx_spd;
        logic [3:0] rx_ack;
    } autrf_state_t;
endpackage

// file: src/autrf_framer.sv
// Purpose: unformatted transmit path and asynchronous receive sorter
// Assumes: link core runs on SYS_CLK; apb master per amba apb
// Notes:   rx buffer read one word per apb read of the data register
//
// Our own choices: register access over APB and the placing of the registers.
`include "autrf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module autrf_framer #(
    parameter int RX_DEPTH = `AUTRF_RX_DEPTH // receive buffer words
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [31:0] TX_DATA,
    output logic TX_VALID,
    output logic TX_FIRST,
    output logic TX_LAST,
    output logic TX_CRC_EN,
    input wire logic TX_READY,
    input wire logic BUS_RESET,
    input wire logic RX_VALID,
    input wire logic RX_FIRST,
    input wire logic [31:0] RX_DATA,
    input wire logic RX_END,
    input wire logic [1:0] RX_SPEED,
    input wire logic [3:0] RX_ACK
);
    // ---------------------------------------------------------------
    // elaboration check
    // ---------------------------------------------------------------
    // pointers are six bits wide, so the buffer cannot grow past 64
    if (RX_DEPTH < 8 || RX_DEPTH > `AUTRF_RX_DEPTH) begin : g_bad_depth
        $error("RX_DEPTH must lie between 8 and 64");
    end

    // ---------------------------------------------------------------
    // state and buffer
    // ---------------------------------------------------------------
    autrf_pkg::autrf_state_t s; // registered state
    autrf_pkg::autrf_state_t next_s; // next state
    logic [31:0] rx_mem [0:RX_DEPTH-1]; // receive entries
    logic mem_we; // buffer write strobe
    logic [31:0] mem_wd; // buffer write word
    logic pop; // apb read drained one word
    logic setup; // apb setup cycle
    logic done; // apb access completes
    logic tx_addr; // address of a tx quadlet register
    logic mapped; // address decodes
    logic rx_full; // buffer has no room
    logic [15:0] rx_len; // data length of 4th quadlet
    logic [16:0] len_sum; // length rounded to words
    logic [5:0] last_ptr; // highest pointer value

    // apb phase decode
    assign setup = PSEL && !PENABLE;
    assign tx_addr = PADDR == `AUTRF_A_TXCTL || PADDR == `AUTRF_A_TXDAT
        || PADDR == `AUTRF_A_TXEND;
    assign mapped = tx_addr || PADDR == `AUTRF_A_TXSTA || PADDR == `AUTRF_A_RXDAT
        || PADDR == `AUTRF_A_RXCNT || PADDR == `AUTRF_A_RXINF;
    // a tx write waits while the holding quadlet is still unsent
    assign PREADY = !(PSEL && PENABLE && PWRITE && tx_addr && s.tx_full);
    assign done = PSEL && PENABLE && PREADY;
    assign pop = done && !PWRITE && PADDR == `AUTRF_A_RXDAT && s.rx_cnt != 7'h00;
    // count is a bit wider than the pointers, so full is exact
    assign rx_full = s.rx_cnt == 7'(RX_DEPTH);
    assign rx_len = RX_DATA[31:16];
    // byte length rounded up to whole quadlets
    assign len_sum = {1'b0, rx_len} + 17'h0_0003;
    assign last_ptr = 6'(RX_DEPTH - 1);

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign PRDATA = s.prdata;
    assign PSLVERR = s.pslverr;
    assign TX_DATA = s.txq.data;
    assign TX_VALID = s.tx_full;
    assign TX_FIRST = s.txq.first;
    assign TX_LAST = s.txq.last;
    assign TX_CRC_EN = s.txq.crc_en;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s = s;
        mem_we = 1'b0;
        mem_wd = 32'h0000_0000;
        // read data is captured in setup so it comes from a flop
        if (setup) begin
            next_s.pslverr = !mapped;
            next_s.prdata = 32'h0000_0000;
            if (!PWRITE) begin
                case (PADDR)
                    `AUTRF_A_TXSTA: begin
                        next_s.prdata = {12'h000, s.gap_pend, s.cfg_gapcnt, s.cfg_gap,
                            s.cfg_target, s.cfg_root, s.tx_inv_bad, s.tx_kind,
                            s.tx_unf, s.tx_full};
                    end
                    `AUTRF_A_RXDAT: begin
                        // empty buffer reads as zero
                        if (s.rx_cnt != 7'h00) begin
                            next_s.prdata = rx_mem[s.rx_rp];
                        end
                    end
                    `AUTRF_A_RXCNT: begin
                        next_s.prdata = {15'h0000, s.rx_ovf, 9'h000, s.rx_cnt};
                    end
                    `AUTRF_A_RXINF: begin
                        // only 15 ext bits fit the word
                        next_s.prdata = {s.rx_ext[14:0], s.rx_spd, s.rx_local, s.rx_bcast,
                            s.rx_bad, s.rx_ack, s.rx_tcode, s.rx_retry, s.rx_fmt};
                    end
                    default: begin
                        next_s.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        // link took the holding quadlet
        if (s.tx_full && TX_READY) begin
            next_s.tx_full = 1'b0;
        end
        // bus reset makes the sent gap count live, so it is no longer pending
        if (BUS_RESET) begin
            next_s.gap_pend = 1'b0;
        end
        // software clears the overflow flag by writing one
        if (done && PWRITE && PADDR == `AUTRF_A_RXCNT && PWDATA[`AUTRF_CLR_BIT]) begin
            next_s.rx_ovf = 1'b0;
        end
        // tx quadlet writes
        if (done && PWRITE && tx_addr) begin
            next_s.tx_full = 1'b1;
            next_s.txq.data = PWDATA;
            next_s.txq.first = PADDR == `AUTRF_A_TXCTL;
            next_s.txq.last = PADDR == `AUTRF_A_TXEND;
            if (PADDR == `AUTRF_A_TXCTL) begin
                // control quadlet: tcode E marks an unformatted packet
                next_s.tx_unf = PWDATA[7:4] == `AUTRF_TC_PHY;
                next_s.txq.crc_en = PWDATA[7:4] != `AUTRF_TC_PHY;
                next_s.tx_idx = 2'h1;
            end else begin
                next_s.txq.crc_en = !s.tx_unf;
                if (s.tx_idx != 2'h3) begin
                    next_s.tx_idx = s.tx_idx + 2'h1;
                end
                if (s.tx_unf && s.tx_idx == 2'h1) begin
                    // second quadlet: watched only, never altered
                    next_s.tx_q2 = PWDATA;
                    next_s.tx_kind = PWDATA[31:30];
                    next_s.cfg_target = PWDATA[29:24];
                    next_s.cfg_root = PWDATA[31:30] == `AUTRF_PKT_CFG && PWDATA[23];
                    next_s.cfg_gap = PWDATA[31:30] == `AUTRF_PKT_CFG && PWDATA[22];
                    next_s.cfg_gapcnt = PWDATA[21:16];
                    if (PWDATA[31:30] == `AUTRF_PKT_CFG && PWDATA[22]) begin
                        next_s.gap_pend = 1'b1;
                    end
                end
                if (s.tx_unf && s.tx_idx == 2'h2) begin
                    // core adds no inverse; flag a host that forgot it
                    next_s.tx_inv_bad = PWDATA != ~s.tx_q2;
                end
            end
        end
        // receive side, one quadlet per cycle
        if (RX_VALID && RX_FIRST) begin
            next_s.rx_tcode = RX_DATA[7:4];
            next_s.rx_retry = RX_DATA[9:8];
            next_s.rx_bcast = RX_DATA[21:16] == `AUTRF_BCAST_NODE;
            next_s.rx_local = RX_DATA[31:22] == 10'h000;
            next_s.rx_ext = 16'h0000;
            next_s.rx_idx = 2'h1;
            next_s.rx_bad = 1'b0;
            next_s.rx_ph = autrf_pkg::RXP_HDR;
            case (RX_DATA[7:4])
                `AUTRF_TC_RDQ, `AUTRF_TC_WRS: begin
                    next_s.rx_fmt = autrf_pkg::FMT_NODATA;
                end
                `AUTRF_TC_WRQ, `AUTRF_TC_RSQ, `AUTRF_TC_RDB: begin
                    next_s.rx_fmt = autrf_pkg::FMT_QUAD;
                end
                `AUTRF_TC_LKQ, `AUTRF_TC_LKS, `AUTRF_TC_WRB, `AUTRF_TC_RSB: begin
                    next_s.rx_fmt = autrf_pkg::FMT_BLOCK;
                end
                default: begin
                    // unknown layout: nothing of it is stored
                    next_s.rx_fmt = autrf_pkg::FMT_NONE;
                    next_s.rx_bad = 1'b1;
                    next_s.rx_ph = autrf_pkg::RXP_SKIP;
                end
            endcase
            if (next_s.rx_fmt != autrf_pkg::FMT_NONE) begin
                mem_we = 1'b1;
                mem_wd = RX_DATA;
            end
        end else if (RX_VALID) begin
            case (s.rx_ph)
                autrf_pkg::RXP_HDR: begin
                    // source id and offset or rcode kept as received
                    mem_we = 1'b1;
                    mem_wd = RX_DATA;
                    next_s.rx_idx = s.rx_idx + 2'h1;
                    if (s.rx_fmt == autrf_pkg::FMT_NODATA && s.rx_idx == 2'h2) begin
                        next_s.rx_ph = autrf_pkg::RXP_SKIP;
                    end else if (s.rx_idx == 2'h3) begin
                        next_s.rx_ph = autrf_pkg::RXP_SKIP;
                        if (s.rx_fmt == autrf_pkg::FMT_BLOCK) begin
                            next_s.rx_ext = RX_DATA[15:0];
                            next_s.rx_left = len_sum[16:2];
                            if (rx_len != 16'h0000) begin
                                next_s.rx_ph = autrf_pkg::RXP_PAY;
                            end
                        end
                    end
                end
                autrf_pkg::RXP_PAY: begin
                    // payload stored word for word, no byte swap
                    mem_we = 1'b1;
                    mem_wd = RX_DATA;
                    next_s.rx_left = s.rx_left - 15'h0001;
                    if (s.rx_left == 15'h0001) begin
                        next_s.rx_ph = autrf_pkg::RXP_SKIP;
                    end
                end
                default: begin
                    // extra quadlets, e.g. crc words, are dropped
                    mem_we = 1'b0;
                end
            endcase
        end else if (RX_END && s.rx_ph != autrf_pkg::RXP_IDLE) begin
            next_s.rx_ph = autrf_pkg::RXP_IDLE;
            next_s.rx_spd = RX_SPEED;
            next_s.rx_ack = RX_ACK;
            if (s.rx_fmt != autrf_pkg::FMT_NONE) begin
                mem_we = 1'b1;
                mem_wd = {14'h0000, RX_SPEED, 12'h000, RX_ACK};
            end
        end
        // overflow drops the word; the flag set wins over a clear
        if (mem_we && rx_full) begin
            mem_we = 1'b0;
            next_s.rx_ovf = 1'b1;
        end
        // write pointer wraps at the last entry
        if (mem_we) begin
            next_s.rx_wp = (s.rx_wp == last_ptr) ? 6'h00 : s.rx_wp + 6'h01;
        end
        // read pointer moves on a completed read only
        if (pop) begin
            next_s.rx_rp = (s.rx_rp == last_ptr) ? 6'h00 : s.rx_rp + 6'h01;
        end
        // a push and a pop together keep the count
        next_s.rx_cnt = s.rx_cnt + {6'h00, mem_we} - {6'h00, pop};
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // one bank of flops, cleared as a whole
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // buffer has no reset; only written words are ever read
    always_ff @(posedge SYS_CLK) begin
        if (mem_we) begin
            rx_mem[s.rx_wp] <= mem_wd;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // one clock domain, so one default serves all
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    // strobes for the transmit checks
    logic ctl_wr; // control quadlet accepted
    logic q2_wr; // second unformatted quadlet accepted
    assign ctl_wr = done && PWRITE && PADDR == `AUTRF_A_TXCTL;
    assign q2_wr = done && PWRITE && tx_addr && !ctl_wr && s.tx_unf && s.tx_idx == 2'h1;

    // transmit side
    phy_no_crc_a: assert property (ctl_wr && PWDATA[7:4] == `AUTRF_TC_PHY
        |=> TX_VALID && TX_FIRST && !TX_CRC_EN ##1 !TX_CRC_EN || !TX_VALID)
        else $error("unformatted packet carries crc");
    tx_pass_a: assert property (done && PWRITE && tx_addr
        |=> TX_VALID && TX_DATA == $past(PWDATA))
        else $error("tx quadlet altered");
    cfg_decode_a: assert property (q2_wr && PWDATA[31:30] == `AUTRF_PKT_CFG
        |=> s.cfg_root == $past(PWDATA[23]) && s.cfg_target == $past(PWDATA[29:24]))
        else $error("root flag decode wrong");
    gap_hold_a: assert property (q2_wr && PWDATA[31:30] == `AUTRF_PKT_CFG
        && PWDATA[22] |=> s.gap_pend && s.cfg_gapcnt == $past(PWDATA[21:16]))
        else $error("gap count not pending");
    lon_kind_a: assert property (q2_wr && PWDATA[31:30] == `AUTRF_PKT_LON
        |=> s.tx_kind == `AUTRF_PKT_LON && !s.cfg_gap && !s.cfg_root)
        else $error("link-on decode wrong");

    // receive side
    fmt_sort_a: assert property (RX_VALID && RX_FIRST
        && RX_DATA[7:4] == `AUTRF_TC_RDB |=> s.rx_fmt == autrf_pkg::FMT_QUAD)
        else $error("block read request misfiled");
    nodata_len_a: assert property (RX_VALID && RX_FIRST
        && RX_DATA[7:4] == `AUTRF_TC_RDQ ##1 (RX_VALID && !RX_FIRST)[*2]
        |=> s.rx_ph == autrf_pkg::RXP_SKIP)
        else $error("no-data entry too long");
    zero_len_a: assert property (s.rx_ph == autrf_pkg::RXP_HDR
        && s.rx_fmt == autrf_pkg::FMT_BLOCK && s.rx_idx == 2'h3 && RX_VALID
        && !RX_FIRST && rx_len == 16'h0000 |=> s.rx_ph == autrf_pkg::RXP_SKIP)
        else $error("payload stored for zero length");
    status_last_a: assert property (RX_END && !RX_VALID && !rx_full
        && s.rx_ph != autrf_pkg::RXP_IDLE && s.rx_fmt != autrf_pkg::FMT_NONE
        |-> mem_we && mem_wd[3:0] == RX_ACK && mem_wd[17:16] == RX_SPEED)
        else $error("status quadlet wrong");

    // receive header and entry framing
    retry_keep_a: assert property (RX_VALID && RX_FIRST
        |=> s.rx_retry == $past(RX_DATA[9:8]))
        else $error("retry code lost");
    bcast_flag_a: assert property (RX_VALID && RX_FIRST
        |=> s.rx_bcast == ($past(RX_DATA[21:16]) == `AUTRF_BCAST_NODE))
        else $error("broadcast flag wrong");
    pay_count_a: assert property (s.rx_ph == autrf_pkg::RXP_PAY && RX_VALID
        && !RX_FIRST && s.rx_left == 15'h0001 |=> s.rx_ph == autrf_pkg::RXP_SKIP)
        else $error("payload length wrong");
    entry_close_a: assert property (RX_END && !RX_VALID
        && s.rx_ph != autrf_pkg::RXP_IDLE |=> s.rx_ph == autrf_pkg::RXP_IDLE)
        else $error("entry not closed");

    // main scenarios
    cfg_sent_c: cover property (q2_wr && PWDATA[31:30] == `AUTRF_PKT_CFG
        ##[1:20] TX_VALID && TX_READY && TX_LAST);
    block_rx_c: cover property (s.rx_ph == autrf_pkg::RXP_PAY ##[1:20] RX_END);
    ovf_c: cover property (s.rx_ovf);
    lock_rx_c: cover property (RX_VALID && RX_FIRST && RX_DATA[7:4] == `AUTRF_TC_LKQ);
endmodule // autrf_framer
`default_nettype wire

// file: tb/autrf_link_model.sv
// Purpose: link core stand-in facing the framer
// Assumes: same clock as the framer, ready sampled at the rising edge
// Notes:   rx frames come from rxq, loaded by the bench before rx_send
`timescale 1ns/1ps
`default_nettype none
module autrf_link_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [31:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_first,
    input wire logic tx_last,
    input wire logic tx_crc_en,
    input wire logic [3:0] stall, // ready rises after stall+1 cycles of valid
    output var logic tx_ready,
    output var logic rx_valid,
    output var logic rx_first,
    output var logic [31:0] rx_data,
    output var logic rx_end,
    output var logic [1:0] rx_speed,
    output var logic [3:0] rx_ack
);
    logic [31:0] txw [0:15]; // quadlets taken, in order
    logic [1:0] txfl [0:15]; // first and last flag of each
    logic [3:0] tx_n; // quadlets taken, wraps
    logic [3:0] wait_n; // stall counter
    logic crc_seen; // any crc request seen
    logic [31:0] rxq [0:7]; // next frame to send
    // ----------------------------------------------------------
    // tx side: take one quadlet once the stall has run out
    // ----------------------------------------------------------
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_ready <= 1'b0;
            tx_n <= 4'h0;
            wait_n <= 4'h0;
            crc_seen <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            txw[tx_n] <= tx_data;
            txfl[tx_n] <= {tx_first, tx_last};
            crc_seen <= crc_seen | tx_crc_en;
            tx_n <= tx_n + 4'h1;
            tx_ready <= 1'b0;
            wait_n <= 4'h0;
        end else if (tx_valid) begin
            tx_ready <= (wait_n >= stall);
            wait_n <= wait_n + 4'h1;
        end
    end
    // ----------------------------------------------------------
    // rx side: idle lines show the inverse, never a stale value
    // ----------------------------------------------------------
    initial begin
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_data = 32'h0000_0000;
        rx_end = 1'b0;
        rx_speed = 2'h3;
        rx_ack = 4'hF;
    end
    // one frame, then status strobe one cycle after the last word
    task automatic rx_send(input int n, input logic [1:0] spd, input logic [3:0] ack);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rx_valid <= 1'b1;
            rx_first <= (i == 0);
            rx_data <= rxq[i];
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        rx_data <= ~rxq[n-1];
        rx_end <= 1'b1;
        rx_speed <= spd;
        rx_ack <= ack;
        @(posedge sys_clk);
        rx_end <= 1'b0;
        rx_speed <= ~spd;
        rx_ack <= ~ack;
    endtask
endmodule // autrf_link_model
`default_nettype wire

// file: tb/autrf_framer_tb.sv
// Purpose: self-checking bench of the framer
// Assumes: link model on the far side, apb driven from here
// Notes:   rx entries checked by count and word by word
`timescale 1ns/1ps
`default_nettype none
`include "autrf_cfg.svh"
module autrf_framer_tb;
    logic SYS_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BUS_RESET;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, TX_DATA, RX_DATA;
    logic TX_VALID, TX_FIRST, TX_LAST, TX_CRC_EN, TX_READY, RX_VALID, RX_FIRST, RX_END;
    logic [1:0] RX_SPEED;
    logic [3:0] RX_ACK, link_stall;
    int mismatches, comparisons;
    // rx table: tcode and block length per case, words sent
    localparam logic [3:0] TC [0:8] = '{`AUTRF_TC_RDQ, `AUTRF_TC_WRS, `AUTRF_TC_WRQ,
        `AUTRF_TC_RSQ, `AUTRF_TC_RDB, `AUTRF_TC_WRB, `AUTRF_TC_LKQ, `AUTRF_TC_RSB, `AUTRF_TC_LKS};
    localparam logic [15:0] LEN [0:8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0005, 16'h0008, 16'h0000, 16'h0004};
    localparam int NS [0:8] = '{3, 3, 4, 4, 4, 6, 6, 4, 5};
    autrf_framer u_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_FIRST(TX_FIRST),
        .TX_LAST(TX_LAST), .TX_CRC_EN(TX_CRC_EN), .TX_READY(TX_READY), .BUS_RESET(BUS_RESET),
        .RX_VALID(RX_VALID), .RX_FIRST(RX_FIRST), .RX_DATA(RX_DATA), .RX_END(RX_END),
        .RX_SPEED(RX_SPEED), .RX_ACK(RX_ACK));
    autrf_link_model u_link (.sys_clk(SYS_CLK), .sys_rst(SYS_RST), .tx_data(TX_DATA),
        .tx_valid(TX_VALID), .tx_first(TX_FIRST), .tx_last(TX_LAST), .tx_crc_en(TX_CRC_EN),
        .stall(link_stall), .tx_ready(TX_READY), .rx_valid(RX_VALID), .rx_first(RX_FIRST),
        .rx_data(RX_DATA), .rx_end(RX_END), .rx_speed(RX_SPEED), .rx_ack(RX_ACK));
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    // one apb transfer; ready and data taken at the rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        k = 0;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1) begin
            k++;
            if (k > 100) begin
                mismatches++;
                test_done();
            end
            @(posedge SYS_CLK);
        end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // control quadlet, second quadlet, its inverse; all must arrive verbatim
    task automatic tx_pkt(input logic [31:0] q2);
        logic [31:0] r, w [0:2];
        logic e;
        logic [3:0] n0;
        int k;
        w = '{32'h0000_00E0, q2, ~q2};
        n0 = u_link.tx_n;
        apb(1'b1, `AUTRF_A_TXCTL, w[0], r, e);
        apb(1'b1, `AUTRF_A_TXDAT, w[1], r, e);
        apb(1'b1, `AUTRF_A_TXEND, w[2], r, e);
        for (k = 0; k < 200 && u_link.tx_n != n0 + 4'h3; k++) begin
            @(posedge SYS_CLK);
        end
        if (k == 200) begin
            mismatches++;
            test_done();
        end
        for (int i = 0; i < 3; i++) begin
            chk("tx_word", w[i], u_link.txw[n0+4'(i)]);
            chk("tx_flags", {30'h0, i == 0, i == 2}, {30'h0, u_link.txfl[n0+4'(i)]});
        end
        chk("tx_crc", 32'h0, {31'h0, u_link.crc_seen});
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    // config packet with slow link: root, gap flag, gap held until bus reset
    task automatic tx_config();
        logic [31:0] r;
        logic e;
        link_stall <= 4'h3;
        tx_pkt(32'h05EA_0000);
        apb(1'b0, `AUTRF_A_TXSTA, 32'h0, r, e);
        chk("tx_cfg", {15'h0, 17'h1_AA2C}, {15'h0, r[19:4], r[3]});
        @(posedge SYS_CLK);
        BUS_RESET <= 1'b1;
        @(posedge SYS_CLK);
        BUS_RESET <= 1'b0;
        apb(1'b0, `AUTRF_A_TXSTA, 32'h0, r, e);
        chk("gap_after_reset", {25'h0, 7'h2A}, {25'h0, r[19], r[18:13]});
    endtask
    // link-on packet, prompt link
    task automatic tx_linkon();
        logic [31:0] r;
        logic e;
        link_stall <= 4'h0;
        tx_pkt(32'h4900_0000);
        apb(1'b0, `AUTRF_A_TXSTA, 32'h0, r, e);
        chk("tx_kind", 32'h1, {30'h0, r[3:2]});
    endtask
    // all nine stored tcodes: entry size, verbatim words, status last
    task automatic rx_sorts();
        logic [31:0] r, st;
        logic e;
        for (int c = 0; c < 9; c++) begin
            for (int k = 0; k < 8; k++) begin
                u_link.rxq[k] = {8'h5A, 8'(c), 8'h00, 8'(k)};
            end
            u_link.rxq[0] = {16'hFFC5, 6'h00, 2'(c), TC[c], 4'h0};
            if (c >= 5) begin
                u_link.rxq[3] = {LEN[c], (c == 6) ? 16'h0002 : 16'h0000};
            end
            st = {14'h0, 2'(c % 3), 12'h0, 4'(c + 1)};
            u_link.rx_send(NS[c], 2'(c % 3), 4'(c + 1));
            apb(1'b0, `AUTRF_A_RXCNT, 32'h0, r, e);
            chk("rx_count", NS[c] + 1, {25'h0, r[6:0]});
            for (int k = 0; k < NS[c]; k++) begin
                apb(1'b0, `AUTRF_A_RXDAT, 32'h0, r, e);
                chk("rx_word", u_link.rxq[k], r);
            end
            apb(1'b0, `AUTRF_A_RXDAT, 32'h0, r, e);
            chk("rx_status", st, r);
            st = {(c == 6) ? 15'h0002 : 15'h0000, 2'(c % 3), 3'h0, 4'(c + 1), TC[c], 2'(c),
                (c < 2) ? 2'h0 : (c < 5) ? 2'h1 : 2'h2};
            apb(1'b0, `AUTRF_A_RXINF, 32'h0, r, e);
            chk("rx_info", st, r);
        end
    endtask
    // unmapped place errors, empty buffer reads zero
    task automatic apb_refuse();
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        apb(1'b0, `AUTRF_A_RXDAT, 32'h0, r, e);
        chk("rx_empty", 32'h0, r);
    endtask
    // ----------------------------------------------------------
    // clock and main sequence
    // ----------------------------------------------------------
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        mismatches = 0;
        comparisons = 0;
        {PSEL, PENABLE, PWRITE, BUS_RESET} = 4'h0;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
        link_stall = 4'h0;
        SYS_RST = 1'b1;
        repeat (3) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        apb_refuse();
        tx_config();
        tx_linkon();
        rx_sorts();
        test_done();
    end
endmodule // autrf_framer_tb
`default_nettype wire
